// *** src/ssu_top.sv ***
// serial shift unit: 8-bit shift register, receive buffer, 4-bit counter,
// start/stop/overflow/collision status, behind an Avalon-MM slave.
// assumes serial pins arrive asynchronous; port bits, timer match and
// global enable come from logic on the same clock.

`timescale 1ns/1ps

module ssu_top
	import ssu_pkg::*;
(
	input  wire logic         clock,
	input  wire logic         rst_n,
	input  wire logic [3:0]   avs_address,
	input  wire logic         avs_read,
	input  wire logic         avs_write,
	input  wire logic [31:0]  avs_writedata,
	input  wire logic [3:0]   avs_byteenable,
	output logic [31:0]       avs_readdata,
	output logic              avs_waitrequest,
	input  wire logic         serial_in_pin,
	input  wire logic         serial_clock_pin,
	input  wire ssu_port_t    port_in,
	input  wire logic         timer_match,
	input  wire logic         global_int_enable,
	output ssu_pin_out_t      pin_out,
	output logic              overflow_irq,
	output logic              start_irq,
	output logic              wake_idle,
	output logic              wake_all
);

	// pin synchronisers and edge history
	logic        sin_s1_r;
	logic        sin_s2_r;
	logic        sin_d_r;
	logic        sck_s1_r;
	logic        sck_s2_r;
	logic        sck_d_r;

	// bus
	logic        wait_r;
	logic [31:0] rdata_r;

	// control
	logic        sie_r;
	logic        oie_r;
	logic [1:0]  wm_r;
	logic [1:0]  cs_r;
	logic        clk_sel_r;

	// datapath and status
	logic [7:0]  sdr_r;
	logic [7:0]  sdr_nxt;
	logic [7:0]  rbuf_r;
	logic [3:0]  cnt_r;
	logic        start_r;
	logic        ovf_r;
	logic        stop_r;
	logic        latch_r;
	logic        hold_start_r;
	ssu_pin_out_t pin_r;
	logic        ovf_irq_r;
	logic        start_irq_r;

	// decoded events
	logic        req;
	logic        acc;
	logic        wr;
	logic        wr_data;
	logic        wr_stat;
	logic        wr_ctrl;
	logic [1:0]  cs_eff;
	logic        clk_eff;
	logic        tc_strobe;
	logic        sw_strobe;
	logic        scl_rise;
	logic        scl_fall;
	logic        sda_q;
	logic        two_wire;
	logic        start_cond;
	logic        stop_cond;
	logic        cnt_tick;
	logic        shift_tick;
	logic        ovf_set;
	logic        start_set;
	logic        start_clr;
	logic        ovf_clr;
	logic        latch_open;
	logic [7:0]  status_view;
	logic [7:0]  ctrl_view;

	// the second stage of each synchroniser feeds the logic; the delayed third copy feeds only the edge and start/stop detectors
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sin_s1_r <= 1'b1;
			sin_s2_r <= 1'b1;
			sin_d_r  <= 1'b1;
			sck_s1_r <= 1'b1;
			sck_s2_r <= 1'b1;
			sck_d_r  <= 1'b1;
		end else begin
			sin_s1_r <= serial_in_pin;
			sin_s2_r <= sin_s1_r;
			sin_d_r  <= sin_s2_r;
			sck_s1_r <= serial_clock_pin;
			sck_s2_r <= sck_s1_r;
			sck_d_r  <= sck_s2_r;
		end
	end

	assign sda_q    = sin_s2_r;
	assign scl_rise = sck_s2_r & ~sck_d_r;
	assign scl_fall = ~sck_s2_r & sck_d_r;
	assign two_wire = wm_r[1];

	// bus slave: one wait cycle, then one cycle with waitrequest low
	assign req     = avs_read | avs_write;
	assign acc     = req & ~wait_r;
	assign wr      = acc & avs_write & avs_byteenable[0];
	assign wr_data = wr & (avs_address == SSU_OFF_DATA);
	assign wr_stat = wr & (avs_address == SSU_OFF_STATUS);
	assign wr_ctrl = wr & (avs_address == SSU_OFF_CTRL);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			wait_r <= 1'b1;
		else
			wait_r <= ~(req & wait_r);
	end

	assign status_view = {start_r, ovf_r, stop_r,
		sdr_r[7] ^ sda_q, cnt_r};
	// strobe bits are write-only and read as zero
	assign ctrl_view = {sie_r, oie_r, wm_r, cs_r, 2'b00};

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 32'h0000_0000;
		end else if (req & wait_r & avs_read) begin
			unique case (avs_address)
			SSU_OFF_DATA:   rdata_r <= {24'h00_0000, sdr_r};
			SSU_OFF_BUFFER: rdata_r <= {24'h00_0000, rbuf_r};
			SSU_OFF_STATUS: rdata_r <= {24'h00_0000, status_view};
			SSU_OFF_CTRL:   rdata_r <= {24'h00_0000, ctrl_view};
			default:        rdata_r <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			{sie_r, oie_r, wm_r, cs_r} <= SSU_CTRL_RST[7:2];
			clk_sel_r <= SSU_CTRL_RST[SSU_CT_CLK];
		end else if (wr_ctrl) begin
			sie_r     <= avs_writedata[SSU_CT_SIE];
			oie_r     <= avs_writedata[SSU_CT_OIE];
			wm_r      <= avs_writedata[SSU_CT_WM_HI:SSU_CT_WM_LO];
			cs_r      <= avs_writedata[SSU_CT_CS_HI:SSU_CT_CS_LO];
			clk_sel_r <= avs_writedata[SSU_CT_CLK];
		end
	end

	// a control write's clock select and strobes act in that very cycle; wire mode and the latch use the stored values
	assign cs_eff    = wr_ctrl ? avs_writedata[SSU_CT_CS_HI:SSU_CT_CS_LO]
		: cs_r;
	assign clk_eff   = wr_ctrl ? avs_writedata[SSU_CT_CLK] : clk_sel_r;
	assign sw_strobe = wr_ctrl & avs_writedata[SSU_CT_CLK];
	assign tc_strobe = wr_ctrl & avs_writedata[SSU_CT_TOGGLE];

	// clock sources; pins are read in every wire mode
	always_comb begin
		unique case (cs_eff)
		SSU_CS_SOFT: begin
			cnt_tick   = sw_strobe;
			shift_tick = sw_strobe;
		end
		SSU_CS_TIMER: begin
			cnt_tick   = timer_match;
			shift_tick = timer_match;
		end
		default: begin
			if (clk_eff) begin
				cnt_tick   = tc_strobe;
				shift_tick = tc_strobe;
			end else begin
				cnt_tick   = scl_rise | scl_fall;
				shift_tick = cs_eff[0] ? scl_fall : scl_rise;
			end
		end
		endcase
	end

	// a data write beats a coincident shift
	always_comb begin
		if (wr_data)
			sdr_nxt = avs_writedata[7:0];
		else if (shift_tick)
			sdr_nxt = {sdr_r[6:0], sda_q};
		else
			sdr_nxt = sdr_r;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			sdr_r <= SSU_DATA_RST;
		else
			sdr_r <= sdr_nxt;
	end

	// counter; a status write beats a coincident tick
	assign ovf_set = cnt_tick & ~wr_stat & (cnt_r == SSU_CNT_MAX);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			cnt_r <= SSU_STATUS_RST[3:0];
		else if (wr_stat)
			cnt_r <= avs_writedata[3:0];
		else if (cnt_tick)
			cnt_r <= cnt_r + 4'h1;
	end

	// buffer holds the completed byte so a read never races the next shift
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			rbuf_r <= SSU_DATA_RST;
		else if (ovf_set)
			rbuf_r <= sdr_nxt;
	end

	// start and stop detection on the synchronised lines
	assign start_cond = two_wire & sck_s2_r & sin_d_r & ~sda_q;
	assign stop_cond  = two_wire & sck_s2_r & ~sin_d_r & sda_q;
	assign start_set  = start_cond | (~two_wire & cs_eff[1] & ~clk_eff
		& (scl_rise | scl_fall));
	assign start_clr  = wr_stat & avs_writedata[SSU_ST_START];
	assign ovf_clr    = wr_stat & avs_writedata[SSU_ST_OVF];

	// sticky flags: a set in the clearing cycle wins
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			start_r <= SSU_STATUS_RST[SSU_ST_START];
			ovf_r   <= SSU_STATUS_RST[SSU_ST_OVF];
			stop_r  <= SSU_STATUS_RST[SSU_ST_STOP];
		end else begin
			start_r <= start_set | (start_r & ~start_clr);
			ovf_r   <= ovf_set | (ovf_r & ~ovf_clr);
			stop_r  <= stop_cond | (stop_r
				& ~(wr_stat & avs_writedata[SSU_ST_STOP]));
		end
	end

	// start hold grabs the clock line once the master pulls it low
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			hold_start_r <= 1'b0;
		else if (~two_wire | start_clr)
			hold_start_r <= 1'b0;
		else if (start_r & scl_fall)
			hold_start_r <= 1'b1;
	end

	// output latch: external clock opens it on the phase before sampling
	assign latch_open = ~cs_r[1] | (sck_s2_r == cs_r[0]);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			latch_r <= SSU_DATA_RST[7];
		else if (latch_open)
			latch_r <= sdr_nxt[7];
	end

	// pin drive; nothing leaves the data pin without its direction bit
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pin_r <= '0;
		end else begin
			pin_r.do_val  <= latch_r;
			pin_r.do_oe   <= (wm_r == SSU_WM_THREE)
				& port_in.ddr_data;
			pin_r.sda_val <= 1'b0;
			pin_r.sda_oe  <= two_wire & port_in.ddr_data
				& (~latch_r | ~port_in.port_data);
			pin_r.scl_val <= 1'b0;
			pin_r.scl_oe  <= two_wire & port_in.ddr_clock
				& (~port_in.port_clock | hold_start_r
				| ((wm_r == SSU_WM_TWO_OVF) & ovf_r));
		end
	end

	// requests follow the flags, so a pending flag fires when enabled
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ovf_irq_r   <= 1'b0;
			start_irq_r <= 1'b0;
		end else begin
			ovf_irq_r   <= ovf_r & oie_r & global_int_enable;
			start_irq_r <= start_r & sie_r & global_int_enable;
		end
	end

	assign avs_readdata    = rdata_r;
	assign avs_waitrequest = wait_r;
	assign pin_out         = pin_r;
	assign overflow_irq    = ovf_irq_r;
	assign start_irq       = start_irq_r;
	assign wake_idle       = ovf_irq_r;
	assign wake_all        = start_irq_r;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence s_wrap;
		cnt_tick && !wr_stat && cnt_r == SSU_CNT_MAX;
	endsequence

	sequence s_ovf_pending;
		ovf_r && !ovf_set;
	endsequence

	a_ovf_wrap_set: assert property (
		s_wrap |=> ovf_r && cnt_r == 4'h0)
		else $error("wrap did not set overflow or reach zero");

	a_ovf_only_clear: assert property (
		ovf_r && !ovf_clr |=> ovf_r)
		else $error("overflow flag dropped without a written one");

	a_ovf_irq_req: assert property (
		ovf_r && oie_r && global_int_enable |=> overflow_irq && wake_idle)
		else $error("overflow request missing");

	a_start_tw_set: assert property (
		start_cond |=> start_r)
		else $error("start condition did not set start flag");

	a_start_only_clear: assert property (
		start_r && !start_clr |=> start_r)
		else $error("start flag dropped without a written one");

	a_start_irq_req: assert property (
		start_r && sie_r && global_int_enable |=> start_irq && wake_all)
		else $error("start request missing");

	a_stop_set_flag: assert property (
		stop_cond |=> stop_r)
		else $error("stop condition did not set stop flag");

	a_write_wins_shift: assert property (
		wr_data && shift_tick |=> sdr_r == $past(avs_writedata[7:0]))
		else $error("data write lost to a shift");

	a_shift_left_one: assert property (
		shift_tick && !wr_data |=> sdr_r[7:1] == $past(sdr_r[6:0]))
		else $error("shift did not move data left by one");

	a_buffer_copy: assert property (
		ovf_set |=> rbuf_r == sdr_r)
		else $error("buffer not loaded at completion");

	a_pending_fires: assert property (
		s_ovf_pending ##1 (oie_r && global_int_enable && ovf_r)
		|=> overflow_irq)
		else $error("pending overflow not taken when enabled");

	// pin drive is registered, so it shows the flag one edge later
	a_ovf_clock_hold: assert property (
		wm_r == SSU_WM_TWO_OVF && ovf_r && port_in.ddr_clock
		|=> pin_out.scl_oe && !pin_out.scl_val)
		else $error("clock line not held on overflow");

	a_bus_one_wait: assert property (
		req && wait_r |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("waitrequest not low for exactly one cycle");

endmodule

// *** common/ssu_pkg.sv ***
// package for the serial shift unit: register map, field positions,
// reset values, mode codes and the pin carriers.
// assumes a 32-bit Avalon-MM slave with byte addresses, one word per register.
package ssu_pkg;

	// register byte offsets
	localparam logic [3:0] SSU_OFF_DATA   = 4'h0;
	localparam logic [3:0] SSU_OFF_BUFFER = 4'h4;
	localparam logic [3:0] SSU_OFF_STATUS = 4'h8;
	localparam logic [3:0] SSU_OFF_CTRL   = 4'hC;

	// serial_status fields
	localparam int SSU_ST_START = 7;
	localparam int SSU_ST_OVF   = 6;
	localparam int SSU_ST_STOP  = 5;
	localparam int SSU_ST_COLL  = 4;

	// serial_control fields
	localparam int SSU_CT_SIE    = 7;
	localparam int SSU_CT_OIE    = 6;
	localparam int SSU_CT_WM_HI  = 5;
	localparam int SSU_CT_WM_LO  = 4;
	localparam int SSU_CT_CS_HI  = 3;
	localparam int SSU_CT_CS_LO  = 2;
	localparam int SSU_CT_CLK    = 1;
	localparam int SSU_CT_TOGGLE = 0;

	// reset values and the counter's top value
	localparam logic [7:0] SSU_STATUS_RST = 8'h00;
	localparam logic [7:0] SSU_CTRL_RST   = 8'h00;
	localparam logic [7:0] SSU_DATA_RST   = 8'h00;
	localparam logic [3:0] SSU_CNT_MAX    = 4'hF;

	// wire_mode_sel codes
	localparam logic [1:0] SSU_WM_OFF     = 2'h0;
	localparam logic [1:0] SSU_WM_THREE   = 2'h1;
	localparam logic [1:0] SSU_WM_TWO     = 2'h2;
	localparam logic [1:0] SSU_WM_TWO_OVF = 2'h3;

	// clock_select codes
	localparam logic [1:0] SSU_CS_SOFT  = 2'h0;
	localparam logic [1:0] SSU_CS_TIMER = 2'h1;

	// port-register view of the two pins, same clock domain
	typedef struct packed {
		logic ddr_data;
		logic ddr_clock;
		logic port_data;
		logic port_clock;
	} ssu_port_t;

	// pin drive: value and enable per pin, enable high while driving
	typedef struct packed {
		logic do_val;
		logic do_oe;
		logic sda_val;
		logic sda_oe;
		logic scl_val;
		logic scl_oe;
	} ssu_pin_out_t;

endpackage

// *** tb/ssu_link_partner.sv ***
// far-side serial device: drives the clock and data lines of the link.
// assumes the bench wires these through the open-drain pulls of the unit.
`timescale 1ns/1ps

module ssu_link_partner (
	input  wire logic       go,
	input  wire logic [1:0] cmd,
	input  wire logic [7:0] tx_byte,
	output logic            sck,
	output logic            sd,
	output logic            busy
);
	localparam time HALF = 80ns;

	// clock stands high at rest and stays low after a start until the next command; it never runs free
	initial begin
		sck = 1'b1;
		sd = 1'b1;
		busy = 1'b0;
	end

	// cmd 0: byte, msb first, data set while clock low; 1: start; 2: stop
	always @(posedge go) begin
		busy = 1'b1;
		case (cmd)
		2'd0: begin
			for (int i = 7; i >= 0; i--) begin
				sck = 1'b0;
				sd = tx_byte[i];
				#HALF;
				sck = 1'b1;
				#HALF;
			end
			// released line must not keep showing the last bit
			sd = ~sd;
		end
		2'd1: begin
			sd = 1'b0;
			#HALF;
			sck = 1'b0;
			#HALF;
		end
		default: begin
			sd = 1'b0;
			#HALF;
			sck = 1'b1;
			#HALF;
			sd = 1'b1;
			#HALF;
		end
		endcase
		busy = 1'b0;
	end
endmodule

// *** tb/tb_top.sv ***
// bench for the serial shift unit: Avalon-MM tasks and directed tests.
// assumes one wait cycle per access and the link partner model.
`timescale 1ns/1ps

module tb_top
	import ssu_pkg::*;
;
	logic         clock;
	logic         rst_n;
	logic [3:0]   avs_address;
	logic         avs_read;
	logic         avs_write;
	logic [31:0]  avs_writedata;
	logic [3:0]   avs_byteenable;
	logic [31:0]  avs_readdata;
	logic         avs_waitrequest;
	ssu_port_t    port_in;
	logic         timer_match;
	logic         global_int_enable;
	ssu_pin_out_t pin_out;
	logic         overflow_irq;
	logic         start_irq;
	logic         wake_idle;
	logic         wake_all;
	logic         go;
	logic [1:0]   cmd;
	logic [7:0]   tx_byte;
	logic         sck;
	logic         sd;
	logic         busy;
	int           n_mismatch;
	int           checks;

	// wired-and of partner drive and the unit's pull-downs
	wire scl_w = sck & ~pin_out.scl_oe;
	wire sda_w = sd & ~pin_out.sda_oe;

	ssu_top i_ssu_top (
		.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.serial_in_pin(sda_w), .serial_clock_pin(scl_w),
		.port_in(port_in), .timer_match(timer_match),
		.global_int_enable(global_int_enable), .pin_out(pin_out),
		.overflow_irq(overflow_irq), .start_irq(start_irq),
		.wake_idle(wake_idle), .wake_all(wake_all)
	);

	ssu_link_partner i_ssu_link_partner (
		.go(go), .cmd(cmd), .tx_byte(tx_byte),
		.sck(sck), .sd(sd), .busy(busy)
	);

	initial clock = 1'b0;
	always #10 clock = ~clock;

	task automatic results();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen,
			input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// tm raises timer_match for the edge at which the access completes
	task automatic bus(input logic rd, input logic [3:0] a,
			input logic [7:0] d, input logic [3:0] be, input logic tm,
			output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clock);
		avs_read <= rd;
		avs_write <= ~rd;
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_byteenable <= be;
		do begin
			@(posedge clock);
			n++;
			timer_match <= tm && (n == 1);
		end while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		if (n >= 50) begin
			n_mismatch++;
			results();
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d,
			input logic [3:0] be = 4'hF, input logic tm = 1'b0);
		logic [31:0] q;
		bus(1'b0, a, d, be, tm, q);
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp,
			input string name);
		logic [31:0] q;
		bus(1'b1, a, 8'h00, 4'hF, 1'b0, q);
		chk(name, q, {24'h0, exp});
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic tick();
		@(posedge clock);
		timer_match <= 1'b1;
		@(posedge clock);
		timer_match <= 1'b0;
	endtask

	task automatic link(input logic [1:0] c, input logic [7:0] b);
		int n;
		@(posedge clock);
		cmd <= c;
		tx_byte <= b;
		go <= 1'b1;
		@(posedge clock);
		go <= 1'b0;
		n = 0;
		while (busy !== 1'b0 && n < 500) begin
			@(posedge clock);
			n++;
		end
		if (n >= 500) begin
			n_mismatch++;
			results();
		end
		idle(8);
	endtask

	initial begin
		#200us;
		n_mismatch++;
		results();
	end

	initial begin
		rst_n = 1'b0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		port_in = 4'hF;
		timer_match = 1'b0;
		global_int_enable = 1'b1;
		go = 1'b0;
		cmd = 2'd0;
		tx_byte = 8'h00;
		n_mismatch = 0;
		checks = 0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		idle(3);
		// collision reads one: data bit7 low against an idle-high line
		rd_chk(SSU_OFF_STATUS, SSU_STATUS_RST | 8'h10, "status");
		rd_chk(SSU_OFF_CTRL, SSU_CTRL_RST, "control");
		rd_chk(SSU_OFF_BUFFER, 8'h00, "buffer rst");
		rd_chk(4'h1, 8'h00, "unmapped");
		wr(SSU_OFF_DATA, 8'h55, 4'h0);
		rd_chk(SSU_OFF_DATA, SSU_DATA_RST, "data be0");
		wr(SSU_OFF_DATA, 8'hA5);
		repeat (3) wr(SSU_OFF_CTRL, 8'h02);
		rd_chk(SSU_OFF_DATA, 8'h2F, "soft shift");
		rd_chk(SSU_OFF_STATUS, 8'h13, "soft count");
		rd_chk(SSU_OFF_CTRL, 8'h00, "strobe bits");
		wr(SSU_OFF_DATA, 8'h81);
		wr(SSU_OFF_STATUS, 8'h0F);
		wr(SSU_OFF_CTRL, 8'h02);
		rd_chk(SSU_OFF_STATUS, 8'h50, "wrap");
		rd_chk(SSU_OFF_BUFFER, 8'h03, "buffer");
		chk("ovf irq off", overflow_irq, 1'b0);
		wr(SSU_OFF_CTRL, 8'h40);
		idle(2);
		chk("ovf irq", overflow_irq, 1'b1);
		chk("wake idle", wake_idle, 1'b1);
		global_int_enable <= 1'b0;
		idle(3);
		chk("ovf irq gie", overflow_irq, 1'b0);
		global_int_enable <= 1'b1;
		wr(SSU_OFF_STATUS, 8'h00);
		rd_chk(SSU_OFF_STATUS, 8'h50, "ovf kept");
		wr(SSU_OFF_STATUS, 8'h40);
		rd_chk(SSU_OFF_STATUS, 8'h10, "ovf clear");
		wr(SSU_OFF_CTRL, 8'h04);
		repeat (4) tick();
		rd_chk(SSU_OFF_STATUS, 8'h14, "timer count");
		wr(SSU_OFF_DATA, 8'h3C, 4'hF, 1'b1);
		rd_chk(SSU_OFF_DATA, 8'h3C, "write wins");
		rd_chk(SSU_OFF_STATUS, 8'h15, "tick counted");
		repeat (2) wr(SSU_OFF_CTRL, 8'h0B);
		rd_chk(SSU_OFF_STATUS, 8'h07, "toggle count");
		rd_chk(SSU_OFF_DATA, 8'hF3, "toggle shift");
		wr(SSU_OFF_STATUS, 8'hE0);
		wr(SSU_OFF_CTRL, 8'h08);
		link(2'd0, 8'h96);
		rd_chk(SSU_OFF_STATUS, 8'hC0, "pin frame");
		rd_chk(SSU_OFF_DATA, 8'h96, "pin data");
		rd_chk(SSU_OFF_BUFFER, 8'h96, "pin buffer");
		wr(SSU_OFF_CTRL, 8'h88);
		idle(2);
		chk("start irq", start_irq, 1'b1);
		chk("wake all", wake_all, 1'b1);
		wr(SSU_OFF_STATUS, 8'h80);
		idle(2);
		chk("start irq off", start_irq, 1'b0);
		rd_chk(SSU_OFF_STATUS, 8'h40, "start clear");
		wr(SSU_OFF_CTRL, 8'h10);
		wr(SSU_OFF_DATA, 8'h80);
		idle(3);
		chk("do value", pin_out.do_val, 1'b1);
		chk("do enable", pin_out.do_oe, 1'b1);
		wr(SSU_OFF_DATA, 8'h00);
		idle(3);
		chk("do follows", pin_out.do_val, 1'b0);
		wr(SSU_OFF_DATA, 8'hFF);
		wr(SSU_OFF_STATUS, 8'hE0);
		wr(SSU_OFF_CTRL, 8'hEC);
		link(2'd1, 8'h00);
		rd_chk(SSU_OFF_STATUS, 8'h91, "start seen");
		chk("start hold", pin_out.scl_oe, 1'b1);
		chk("start irq 2w", start_irq, 1'b1);
		wr(SSU_OFF_STATUS, 8'h80);
		idle(3);
		chk("hold release", pin_out.scl_oe, 1'b0);
		link(2'd2, 8'h00);
		rd_chk(SSU_OFF_STATUS, 8'h21, "stop seen");
		chk("stop no irq", {start_irq, overflow_irq}, 2'b00);
		wr(SSU_OFF_STATUS, 8'hEF);
		wr(SSU_OFF_CTRL, 8'h32);
		idle(3);
		chk("ovf hold", {pin_out.scl_oe, pin_out.scl_val}, 2'b10);
		wr(SSU_OFF_STATUS, 8'h40);
		idle(3);
		chk("ovf release", pin_out.scl_oe, 1'b0);
		// a zero in bit 7 pulls the data line low while the clock is high,
		// so the unit's own start detector fires and no collision shows
		wr(SSU_OFF_DATA, 8'h00);
		idle(3);
		chk("sda drive", {pin_out.sda_oe, pin_out.sda_val}, 2'b10);
		rd_chk(SSU_OFF_STATUS, 8'h80, "sda sensed");
		results();
	end
endmodule
